// ==== logic/rft_defines.svh ====
`ifndef RFT_DEFINES_SVH
`define RFT_DEFINES_SVH

// Register keys are {long_space, offset[9:0]}
`define RFT_LONG 11'h400
`define RFT_NREG 23

`define RFT_OFS_AMP_ON_TIME 11'h017
`define RFT_OFS_TX_ON_TIME 11'h018
`define RFT_OFS_CLOCK_GATE_CTRL 11'h026
`define RFT_OFS_SOFT_RESET_CTRL 11'h02a
`define RFT_OFS_VCO_CAL_PERIOD 11'h02e
`define RFT_OFS_IRQ_STATUS 11'h031
`define RFT_OFS_IRQ_MASK 11'h032
`define RFT_OFS_RADIO_CTRL 11'h036
`define RFT_OFS_CHANNEL_SELECT 11'h200
`define RFT_OFS_VCO_RX_TUNE 11'h201
`define RFT_OFS_RX_FILTER_TUNE_A 11'h202
`define RFT_OFS_RX_FILTER_TUNE_B 11'h204
`define RFT_OFS_TX_BW_XTAL_TUNE 11'h206
`define RFT_OFS_RX_FILTER_TUNE_C 11'h207
`define RFT_OFS_TX_DC_TUNE 11'h208
`define RFT_OFS_PIN_DIRECTION 11'h23d
`define RFT_OFS_DCDC_TUNE_A 11'h250
`define RFT_OFS_DCDC_TUNE_B 11'h251
`define RFT_OFS_SLEEP_CLOCK_TUNE 11'h252
`define RFT_OFS_PLL_TUNE_A 11'h259
`define RFT_OFS_VCO_PLL_TUNE 11'h273
`define RFT_OFS_AMP_LEVEL_CTRL 11'h274
`define RFT_OFS_SERIAL_CLOCK_TUNE_A 11'h275
`define RFT_OFS_SERIAL_CLOCK_TUNE_B 11'h276

`define RFT_RST_AMP_ON_TIME 8'h02
`define RFT_RST_TX_ON_TIME 8'h88
`define RFT_RST_CLOCK_GATE_CTRL 8'h00
`define RFT_RST_SOFT_RESET_CTRL 8'h00
`define RFT_RST_VCO_CAL_PERIOD 8'h75
`define RFT_RST_IRQ_STATUS 8'h00
`define RFT_RST_IRQ_MASK 8'hff
`define RFT_RST_RADIO_CTRL 8'h00
`define RFT_RST_CHANNEL_SELECT 8'h01
`define RFT_RST_VCO_RX_TUNE 8'h01
`define RFT_RST_RX_FILTER_TUNE_A 8'h84
`define RFT_RST_RX_FILTER_TUNE_B 8'h00
`define RFT_RST_TX_BW_XTAL_TUNE 8'hf0
`define RFT_RST_RX_FILTER_TUNE_C 8'h00
`define RFT_RST_TX_DC_TUNE 8'h0c
`define RFT_RST_PIN_DIRECTION 8'h3f
`define RFT_RST_DCDC_TUNE_A 8'h00
`define RFT_RST_DCDC_TUNE_B 8'h00
`define RFT_RST_SLEEP_CLOCK_TUNE 8'hff
`define RFT_RST_PLL_TUNE_A 8'h01
`define RFT_RST_VCO_PLL_TUNE 8'h00
`define RFT_RST_AMP_LEVEL_CTRL 8'hca
`define RFT_RST_SERIAL_CLOCK_TUNE_A 8'h15
`define RFT_RST_SERIAL_CLOCK_TUNE_B 8'h01

// Field positions
`define RFT_BIT_LINK_RESYNC 5
`define RFT_BIT_TX_MAC_CLK 2
`define RFT_BIT_RADIO_FSM_RST 2
`define RFT_BIT_BASEBAND_RST 1
`define RFT_BIT_MAC_RST 0
`define RFT_BIT_WAKE 6
`define RFT_BIT_RX 3
`define RFT_BIT_TX 0

// Frame layout: header lengths in link clock edges, minus one
`define RFT_SHORT_HDR_LAST 4'd7
`define RFT_LONG_HDR_LAST 4'd11

`endif

// ==== logic/rft_pkg.sv ====
package rft_pkg;
    typedef logic [10:0] rft_key_t;
    typedef logic [7:0] rft_byte_t;
endpackage

// ==== logic/rft_link.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "rft_defines.svh"

module rft_link
    import rft_pkg::*;
(
    input wire logic sclk,
    input wire logic nrst,
    input wire logic senN,
    input wire logic si,
    output logic so,
    input wire rft_byte_t rdData,
    output logic wrTog,
    output logic rdTog,
    output rft_key_t wrKey,
    output rft_byte_t wrData,
    output rft_key_t curKey
);
    // Frame state is cleared by the enable itself, so no edge after it counts
    wire frameRstN = nrst & ~senN;
    logic [10:0] shiftIn;
    logic [3:0] hdrCnt;
    logic [2:0] dataCnt;
    logic [6:0] dataSh;
    logic isLong, isWrite, hdrDone, frameEnd;

    wire hdrLast = !hdrDone && hdrCnt ==
        (isLong ? `RFT_LONG_HDR_LAST : `RFT_SHORT_HDR_LAST);
    wire dataLast = hdrDone && !frameEnd && dataCnt == 3'd7;
    wire rft_key_t hdrKey = isLong ? {1'b1, shiftIn[9:0]}
                                   : {5'h00, shiftIn[5:0]};
    wire rft_key_t nextKey = {curKey[10], curKey[9:0] + 10'h001};

    always_ff @(posedge sclk or negedge frameRstN) begin
        if (!frameRstN) begin
            shiftIn <= 11'h000;
            hdrCnt <= 4'h0;
            dataCnt <= 3'h0;
            dataSh <= 7'h00;
            isLong <= 1'b0;
            isWrite <= 1'b0;
            hdrDone <= 1'b0;
            frameEnd <= 1'b0;
        end else if (!hdrDone) begin
            shiftIn <= {shiftIn[9:0], si};
            hdrCnt <= hdrCnt + 4'h1;
            if (hdrCnt == 4'h0) begin
                isLong <= si;
            end
            if (hdrLast) begin
                hdrDone <= 1'b1;
                isWrite <= si;
            end
        end else if (!frameEnd) begin
            dataCnt <= dataCnt + 3'h1;
            dataSh <= {dataSh[5:0], si};
            // Burst only in long space; short frames stop after one byte
            if (dataLast && !isLong) begin
                frameEnd <= 1'b1;
            end
        end
    end

    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            curKey <= 11'h000;
            wrKey <= 11'h000;
            wrData <= 8'h00;
            wrTog <= 1'b0;
            rdTog <= 1'b0;
        end else if (hdrLast) begin
            curKey <= hdrKey;
            if (!si) begin
                rdTog <= ~rdTog;
            end
        end else if (dataLast) begin
            if (isLong) begin
                curKey <= nextKey;
            end
            if (isWrite) begin
                wrKey <= curKey;
                wrData <= {dataSh, si};
                wrTog <= ~wrTog;
            end else if (isLong) begin
                rdTog <= ~rdTog;
            end
        end
    end

    // rdData is held by the core from well before the half period it is used
    always_ff @(negedge sclk or negedge frameRstN) begin
        if (!frameRstN) begin
            so <= 1'b0;
        end else begin
            so <= hdrDone && !isWrite && !frameEnd &&
                  rdData[3'd7 - dataCnt];
        end
    end
endmodule

`default_nettype wire

// ==== logic/rft_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "rft_defines.svh"

module rft_regs
    import rft_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cen,
    input wire logic sclk,
    input wire logic senN,
    input wire logic si,
    output logic so,
    input wire logic wakeEvent,
    input wire logic rxEvent,
    input wire logic txDoneEvent,
    output logic irqN,
    output logic linkResyncEnable,
    output logic txMacClockEnable,
    output logic radioFsmReset,
    output logic basebandReset,
    output logic macReset,
    output logic [2:0] pinDirection,
    output logic [8*`RFT_NREG-1:0] rfTune
);
    localparam int IDX_GATE = 2;
    localparam int IDX_SOFT = 3;
    localparam int IDX_MASK = 5;
    localparam int IDX_RADIO = 6;
    localparam int IDX_PIN = 14;

    localparam rft_key_t REG_KEY [`RFT_NREG] = '{
        `RFT_OFS_AMP_ON_TIME,
        `RFT_OFS_TX_ON_TIME,
        `RFT_OFS_CLOCK_GATE_CTRL,
        `RFT_OFS_SOFT_RESET_CTRL,
        `RFT_OFS_VCO_CAL_PERIOD,
        `RFT_OFS_IRQ_MASK,
        `RFT_OFS_RADIO_CTRL,
        `RFT_LONG | `RFT_OFS_CHANNEL_SELECT,
        `RFT_LONG | `RFT_OFS_VCO_RX_TUNE,
        `RFT_LONG | `RFT_OFS_RX_FILTER_TUNE_A,
        `RFT_LONG | `RFT_OFS_RX_FILTER_TUNE_B,
        `RFT_LONG | `RFT_OFS_TX_BW_XTAL_TUNE,
        `RFT_LONG | `RFT_OFS_RX_FILTER_TUNE_C,
        `RFT_LONG | `RFT_OFS_TX_DC_TUNE,
        `RFT_LONG | `RFT_OFS_PIN_DIRECTION,
        `RFT_LONG | `RFT_OFS_DCDC_TUNE_A,
        `RFT_LONG | `RFT_OFS_DCDC_TUNE_B,
        `RFT_LONG | `RFT_OFS_SLEEP_CLOCK_TUNE,
        `RFT_LONG | `RFT_OFS_PLL_TUNE_A,
        `RFT_LONG | `RFT_OFS_VCO_PLL_TUNE,
        `RFT_LONG | `RFT_OFS_AMP_LEVEL_CTRL,
        `RFT_LONG | `RFT_OFS_SERIAL_CLOCK_TUNE_A,
        `RFT_LONG | `RFT_OFS_SERIAL_CLOCK_TUNE_B
    };

    localparam rft_byte_t REG_RST [`RFT_NREG] = '{
        `RFT_RST_AMP_ON_TIME,
        `RFT_RST_TX_ON_TIME,
        `RFT_RST_CLOCK_GATE_CTRL,
        `RFT_RST_SOFT_RESET_CTRL,
        `RFT_RST_VCO_CAL_PERIOD,
        `RFT_RST_IRQ_MASK,
        `RFT_RST_RADIO_CTRL,
        `RFT_RST_CHANNEL_SELECT,
        `RFT_RST_VCO_RX_TUNE,
        `RFT_RST_RX_FILTER_TUNE_A,
        `RFT_RST_RX_FILTER_TUNE_B,
        `RFT_RST_TX_BW_XTAL_TUNE,
        `RFT_RST_RX_FILTER_TUNE_C,
        `RFT_RST_TX_DC_TUNE,
        `RFT_RST_PIN_DIRECTION,
        `RFT_RST_DCDC_TUNE_A,
        `RFT_RST_DCDC_TUNE_B,
        `RFT_RST_SLEEP_CLOCK_TUNE,
        `RFT_RST_PLL_TUNE_A,
        `RFT_RST_VCO_PLL_TUNE,
        `RFT_RST_AMP_LEVEL_CTRL,
        `RFT_RST_SERIAL_CLOCK_TUNE_A,
        `RFT_RST_SERIAL_CLOCK_TUNE_B
    };

    // Link side
    logic wrTog, rdTog;
    rft_key_t wrKey, curKey;
    rft_byte_t wrData;
    rft_byte_t rdData;

    // The link only answers frames the host opens
    rft_link linkPort (
        .sclk(sclk),
        .nrst(nrst),
        .senN(senN),
        .si(si),
        .so(so),
        .rdData(rdData),
        .wrTog(wrTog),
        .rdTog(rdTog),
        .wrKey(wrKey),
        .wrData(wrData),
        .curKey(curKey)
    );

    // Toggle synchronisers; key and data are held stable long before
    // the toggle lands, so they are sampled only on the detected edge
    logic [2:0] wrSync;
    logic [2:0] rdSync;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wrSync <= 3'h0;
            rdSync <= 3'h0;
        end else if (cen) begin
            wrSync <= {wrSync[1:0], wrTog};
            rdSync <= {rdSync[1:0], rdTog};
        end
    end

    wire wrStrobe = cen && (wrSync[2] ^ wrSync[1]);
    wire rdStrobe = cen && (rdSync[2] ^ rdSync[1]);

    // Register file
    rft_byte_t regFile [`RFT_NREG];
    logic [`RFT_NREG-1:0] wrHit;
    logic [`RFT_NREG-1:0] rdHit;
    rft_byte_t rdTerm [`RFT_NREG];

    genvar gi;
    generate
        for (gi = 0; gi < `RFT_NREG; gi++) begin : gReg
            assign wrHit[gi] = wrKey == REG_KEY[gi];
            assign rdHit[gi] = curKey == REG_KEY[gi];
            assign rdTerm[gi] = rdHit[gi] ? regFile[gi] : 8'h00;
            assign rfTune[gi*8 +: 8] = regFile[gi];
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    regFile[gi] <= REG_RST[gi];
                end else if (wrStrobe && wrHit[gi]) begin
                    // Soft reset requests act once and never stay stored
                    regFile[gi] <= (gi == IDX_SOFT) ? 8'h00 : wrData;
                end
            end
        end
    endgenerate

    rft_byte_t rdMux;

    always_comb begin
        rdMux = 8'h00;
        for (int i = 0; i < `RFT_NREG; i++) begin
            rdMux = rdMux | rdTerm[i];
        end
    end

    // Interrupt status
    rft_byte_t irqStatus;
    rft_byte_t irqSet;
    rft_byte_t irqClr;
    rft_byte_t next_irqStatus;
    wire statusHit = curKey == `RFT_OFS_IRQ_STATUS;
    wire statusRead = rdStrobe && statusHit;
    wire rft_byte_t irqMask = regFile[IDX_MASK];

    always_comb begin
        irqSet = 8'h00;
        irqSet[`RFT_BIT_WAKE] = wakeEvent;
        irqSet[`RFT_BIT_RX] = rxEvent;
        irqSet[`RFT_BIT_TX] = txDoneEvent;
        irqClr = statusRead ? 8'hff : 8'h00;
        // A new event in the clearing cycle survives the read
        next_irqStatus = (irqStatus & ~irqClr) | irqSet;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irqStatus <= `RFT_RST_IRQ_STATUS;
            irqN <= 1'b1;
        end else if (cen) begin
            irqStatus <= next_irqStatus;
            // Mask of 00 lets every source through; ff blocks all
            irqN <= ~|(next_irqStatus & ~irqMask);
        end
    end

    // Read data stays put until the next read request arrives
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdData <= 8'h00;
        end else if (rdStrobe) begin
            rdData <= statusHit ? irqStatus : rdMux;
        end
    end

    // Soft reset pulses: one core cycle per write of a set bit
    wire softWrite = wrStrobe && wrHit[IDX_SOFT];

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            basebandReset <= 1'b0;
            macReset <= 1'b0;
        end else if (cen) begin
            basebandReset <= softWrite &&
                             wrData[`RFT_BIT_BASEBAND_RST];
            macReset <= softWrite && wrData[`RFT_BIT_MAC_RST];
        end
    end

    // Control outputs straight from the stored registers
    wire rft_byte_t gateVal = regFile[IDX_GATE];
    wire rft_byte_t radioVal = regFile[IDX_RADIO];
    wire rft_byte_t pinVal = regFile[IDX_PIN];

    assign linkResyncEnable = gateVal[`RFT_BIT_LINK_RESYNC];
    assign txMacClockEnable = gateVal[`RFT_BIT_TX_MAC_CLK];
    // Held until radio_ctrl is written again
    assign radioFsmReset = radioVal[`RFT_BIT_RADIO_FSM_RST];
    // A zero bit makes the pin an output
    assign pinDirection = pinVal[2:0];
endmodule

`default_nettype wire

// ==== tb/rft_regs_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "rft_defines.svh"
module rft_regs_properties
    import rft_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cen,
    input wire logic sclk,
    input wire logic senN,
    input wire logic si,
    input wire logic so,
    input wire logic wakeEvent,
    input wire logic rxEvent,
    input wire logic txDoneEvent,
    input wire logic irqN,
    input wire logic linkResyncEnable,
    input wire logic txMacClockEnable,
    input wire logic radioFsmReset,
    input wire logic basebandReset,
    input wire logic macReset,
    input wire logic [2:0] pinDirection,
    input wire logic [8*`RFT_NREG-1:0] rfTune
);
    // Enabled core cycles since the last frame ended; writes land inside 8
    // A frozen core delays its writes, so only enabled cycles count
    logic [7:0] idleCnt;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) idleCnt <= 8'h00;
        else if (!senN) idleCnt <= 8'h00;
        else if (cen && idleCnt != 8'hff) idleCnt <= idleCnt + 8'h01;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    reset_vals_a: assert property (
        $rose(nrst) |-> irqN && pinDirection == 3'h7 && !radioFsmReset
        && !linkResyncEnable) else $error("bad state after reset");
    bb_pulse_a: assert property (
        basebandReset |=> !basebandReset) else $error("baseband pulse long");
    mac_pulse_a: assert property (
        macReset |=> !macReset) else $error("mac pulse long");
    bb_in_frame_a: assert property (
        basebandReset |-> idleCnt < 8'd8) else $error("baseband pulse idle");
    cfg_quiet_a: assert property (
        idleCnt > 8'd8 |-> $stable(pinDirection) && $stable(radioFsmReset)
        && $stable(linkResyncEnable) && $stable(rfTune))
        else $error("config changed without a frame");
    irq_rise_a: assert property (
        $rose(irqN) |-> idleCnt < 8'd8) else $error("irq cleared idle");
    so_idle_a: assert property (
        senN [*3] |-> !so) else $error("so driven outside frame");
    so_edge_a: assert property (
        $changed(so) |-> !sclk) else $error("so changed with sclk high");
    cover property (basebandReset);
    cover property ($fell(irqN));
    cover property ($rose(radioFsmReset));
endmodule
`default_nettype wire

// ==== tb/rft_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module rft_host_model #(
    parameter int HALF = 102
) (
    output logic sclk,
    output logic senN,
    output logic si,
    input wire logic so
);
    // Half period keeps the minimum high and low time of the link clock
    initial begin
        sclk = 1'b0;
        senN = 1'b1;
        si = 1'b0;
    end
    // Host alone opens frames; clock stands low between them
    task automatic xfer(input logic [11:0] hdr, input int nh,
        input logic [7:0] wd, output logic [7:0] rd);
        logic [19:0] fr;
        int i;
        fr = {hdr, wd} << (12 - nh);
        rd = 8'h00;
        senN = 1'b0;
        #HALF;
        for (i = 0; i < nh + 8; i++) begin
            si = fr[19-i];
            #HALF;
            sclk = 1'b1;
            if (i >= nh) rd = {rd[6:0], so};
            #HALF;
            sclk = 1'b0;
        end
        #HALF;
        senN = 1'b1;
        si = ~si;
        #HALF;
    endtask
endmodule
`default_nettype wire

// ==== tb/rft_regs_test.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "rft_defines.svh"
`define CMP(n, e, o) begin samples_checked++; if ((o) !== (e)) begin \
    mismatches++; $display("[ERR] %s expected %h seen %h", n, e, o); end end
module rft_regs_test
    import rft_pkg::*;
;
    typedef struct {string n; rft_byte_t v;} rft_note_t;
    logic core_clk = 1'b0, nrst, cen, sclk, senN, si, so, irqN;
    logic wakeEvent, rxEvent, txDoneEvent, linkResyncEnable;
    logic txMacClockEnable, radioFsmReset, basebandReset, macReset;
    logic [2:0] pinDirection;
    logic [8*`RFT_NREG-1:0] rfTune;
    logic bbSeen = 1'b0, macSeen = 1'b0;
    int mismatches = 0, samples_checked = 0, seed = 12, i;
    rft_note_t expQ[$], cur;
    rft_byte_t obsQ[$], got, r;
    rft_key_t keys[24] = '{11'h026, 11'h017, 11'h018, 11'h02e, 11'h600,
        11'h601, 11'h602, 11'h604, 11'h606, 11'h607, 11'h608, 11'h63d,
        11'h650, 11'h651, 11'h652, 11'h659, 11'h673, 11'h674, 11'h675,
        11'h676, 11'h032, 11'h02a, 11'h036, 11'h036};
    logic [191:0] vals = {96'h2008949501_02e006c0f08c_00,
        96'h07c0010040c6_1307000204_00};
    logic [191:0] rsts = {96'h0002887501_018400f0000c_3f,
        96'h0000ff0100ca_1501ff0000_00};
    always #5 core_clk = ~core_clk;
    rft_host_model host (.sclk(sclk), .senN(senN), .si(si), .so(so));
    rft_regs uut (.core_clk(core_clk), .nrst(nrst), .cen(cen), .sclk(sclk),
        .senN(senN), .si(si), .so(so), .wakeEvent(wakeEvent),
        .rxEvent(rxEvent), .txDoneEvent(txDoneEvent), .irqN(irqN),
        .linkResyncEnable(linkResyncEnable),
        .txMacClockEnable(txMacClockEnable), .radioFsmReset(radioFsmReset),
        .basebandReset(basebandReset), .macReset(macReset),
        .pinDirection(pinDirection), .rfTune(rfTune));
    always @(posedge core_clk) begin
        if (basebandReset === 1'b1) bbSeen <= 1'b1;
        if (macReset === 1'b1) macSeen <= 1'b1;
        if (obsQ.size() > 0 && expQ.size() > 0) begin
            cur = expQ.pop_front();
            got = obsQ.pop_front();
            `CMP(cur.n, cur.v, got)
        end
    end
    function automatic logic [11:0] hdr(rft_key_t k, logic rw);
        return k[10] ? {1'b1, k[9:0], rw} : {5'h00, k[5:0], rw};
    endfunction
    task automatic wr(input rft_key_t k, input rft_byte_t d);
        rft_byte_t x;
        host.xfer(hdr(k, 1'b1), k[10] ? 12 : 8, d, x);
    endtask
    task automatic rd(input string n, input rft_key_t k, input rft_byte_t e);
        rft_byte_t x;
        expQ.push_back('{n, e});
        host.xfer(hdr(k, 1'b0), k[10] ? 12 : 8, 8'h00, x);
        obsQ.push_back(x);
    endtask
    task automatic port(input string n, input rft_byte_t e,
        input rft_byte_t o);
        expQ.push_back('{n, e});
        obsQ.push_back(o);
    endtask
    task automatic pulse(input logic [2:0] e);
        @(negedge core_clk) {wakeEvent, rxEvent, txDoneEvent} = e;
        @(negedge core_clk) {wakeEvent, rxEvent, txDoneEvent} = 3'h0;
        repeat (5) @(negedge core_clk);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #900000;
        mismatches++;
        results();
    end
    initial begin
        nrst = 1'b0;
        cen = 1'b1;
        {wakeEvent, rxEvent, txDoneEvent} = 3'h0;
        repeat (12) @(posedge core_clk);
        @(negedge core_clk) nrst = 1'b1;
        repeat (2) @(negedge core_clk);
        for (i = 0; i < 23; i++) rd("reset", keys[i], rsts[191-8*i-:8]);
        port("pins", 8'h07, {5'h00, pinDirection});
        pulse(3'b100);
        port("irq masked", 8'h01, {7'h00, irqN});
        rd("status", 11'h031, 8'h40);
        $display("reset test done");
        for (i = 0; i < 24; i++) begin
            wr(keys[i], vals[191-8*i-:8]);
            if (i == 0) port("resync", 8'h01, {7'h00, linkResyncEnable});
            if (i == 0) port("txmac", 8'h00, {7'h00, txMacClockEnable});
            if (i == 11) port("pins", 8'h00, {5'h00, pinDirection});
            if (i == 22) port("radio_fsm_reset_bit", 8'h01, {7'h00, radioFsmReset});
            if (i == 23) port("rfrun", 8'h00, {7'h00, radioFsmReset});
        end
        port("bbrst", 8'h01, {7'h00, bbSeen});
        for (i = 0; i < 23; i++) rd("readback", keys[i],
            (keys[i] == 11'h02a || keys[i] == 11'h036) ? 8'h00 :
            vals[191-8*i-:8]);
        $display("init test done");
        r = 8'($random(seed));
        wr(11'h017, r);
        rd("random", 11'h017, r);
        port("tune", r, rfTune[7:0]);
        wr(11'h03f, ~r);
        rd("unmapped", 11'h03f, 8'h00);
        wr(11'h02a, 8'h01);
        port("macrst", 8'h01, {7'h00, macSeen});
        // A write taken while the core is frozen lands once it runs again
        @(negedge core_clk) cen = 1'b0;
        wr(11'h026, 8'h24);
        port("frozen", 8'h00, {7'h00, txMacClockEnable});
        @(negedge core_clk) cen = 1'b1;
        repeat (5) @(negedge core_clk);
        port("txmac", 8'h01, {7'h00, txMacClockEnable});
        port("resync kept", 8'h01, {7'h00, linkResyncEnable});
        $display("access test done");
        pulse(3'b010);
        for (i = 0; i < 50 && irqN !== 1'b0; i++) @(posedge core_clk);
        port("irq low", 8'h00, {7'h00, irqN});
        rd("status", 11'h031, 8'h08);
        port("irq clear", 8'h01, {7'h00, irqN});
        pulse(3'b111);
        rd("status all", 11'h031, 8'h49);
        repeat (2) @(posedge core_clk);
        $display("irq test done");
        results();
    end
endmodule
bind rft_regs rft_regs_properties chk (.core_clk, .nrst, .cen, .sclk, .senN,
    .si, .so, .wakeEvent, .rxEvent, .txDoneEvent, .irqN, .linkResyncEnable,
    .txMacClockEnable, .radioFsmReset, .basebandReset, .macReset,
    .pinDirection, .rfTune);
`default_nettype wire
